/* logic/mft_timer_regs.sv */
// Register block of the dual 16-bit timer with an AXI4-Lite slave.
`timescale 1ns/100ps
module mft_timer_regs (
    // Clock and reset.
    input wire logic aclk,
    input wire logic aresetn,
    // AXI4-Lite write address.
    input wire logic [mft_pkg::ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    // AXI4-Lite write data.
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    // AXI4-Lite write response.
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // AXI4-Lite read address.
    input wire logic [mft_pkg::ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    // AXI4-Lite read data.
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // Timer pin, split into input, output and enable.
    input wire logic timer_pin_one_in,
    output logic timer_pin_one_out,
    output logic timer_pin_one_oe,
    // System timer interrupts.
    output logic timer_irq_one,
    output logic timer_irq_two
);
    import mft_pkg::*;

    // Bus slave state.
    logic awready_reg;
    logic wready_reg;
    logic bvalid_reg;
    logic [1:0] bresp_reg;
    logic arready_reg;
    logic rvalid_reg;
    logic [31:0] rdata_reg;
    logic [1:0] rresp_reg;
    logic [ADDR_W-1:0] waddr_reg;
    logic [31:0] wdata_reg;
    logic [3:0] wstrb_reg;

    // Register state.
    logic [7:0] mode_reg;
    logic [7:0] mode_next;
    logic [7:0] ien_reg;
    logic [3:0] pend_reg;
    logic [3:0] pend_next;
    logic [4:0] presc_reg;
    logic [5:0] cks_reg;
    logic [4:0] pcnt_reg;
    logic [15:0] rc1_reg;
    logic [15:0] rl2_reg;

    // Pin synchroniser and edge history.
    logic pin_s1_reg;
    logic pin_s2_reg;
    logic pin_prev_reg;

    // Output flops.
    logic pin_out_reg;
    logic pin_oe_reg;
    logic irq1_reg;
    logic irq2_reg;

    mft_cnt_if c1 ();
    mft_cnt_if c2 ();

    // Write commit happens once both halves are held and no response waits.
    wire wr_fire = !awready_reg && !wready_reg && !bvalid_reg;
    wire ar_fire = s_axi_arvalid && arready_reg;

    // Write address decode.
    wire wa_cnt1 = (waddr_reg == OFS_CNT1);
    wire wa_cnt2 = (waddr_reg == OFS_CNT2);
    wire wa_rc1 = (waddr_reg == OFS_RC1);
    wire wa_rl2 = (waddr_reg == OFS_RL2);
    wire wa_mode = (waddr_reg == OFS_MODE);
    wire wa_int = (waddr_reg == OFS_INT);
    wire wa_clr = (waddr_reg == OFS_CLR);
    wire wa_pre = (waddr_reg == OFS_PRE);
    wire wa_cks = (waddr_reg == OFS_CKS);
    wire wa_hit = wa_cnt1 | wa_cnt2 | wa_rc1 | wa_rl2 | wa_mode | wa_int
        | wa_clr | wa_pre | wa_cks;

    // Byte lane merge for the 16-bit registers.
    wire [15:0] lane_mask = {{8{wstrb_reg[1]}}, {8{wstrb_reg[0]}}};
    wire byte0 = wr_fire && wstrb_reg[0];
    wire wide = wr_fire && (wstrb_reg[1:0] != 2'h0);

    // Mode control fields.
    wire module_enable_bit = mode_reg[BIT_TEN];
    wire pin_en = mode_reg[BIT_PEN];
    wire edge_rise = mode_reg[BIT_EDG];
    mft_mode_t mode;
    assign mode = mft_mode_t'(mode_reg[1:0]);
    wire is_capture = (mode == MODE_CAPTURE);
    wire is_pwm = (mode == MODE_PWM);
    wire is_dual = (mode == MODE_DUAL);

    // Writes to counts and reloads only land while enabled.
    wire wr_cnt1 = wide && wa_cnt1 && module_enable_bit;
    wire wr_cnt2 = wide && wa_cnt2 && module_enable_bit;
    wire wr_rc1 = wide && wa_rc1 && module_enable_bit;
    wire wr_rl2 = wide && wa_rl2 && module_enable_bit;
    wire wr_mode = byte0 && wa_mode;
    wire wr_int = byte0 && wa_int;
    wire wr_clr = byte0 && wa_clr;

    // Prescaler divides by divisor plus one; it idles at zero while disabled.
    wire pre_tick = module_enable_bit && (pcnt_reg == presc_reg);
    wire tick1 = pre_tick && (cks_reg[2:0] == CKS_PRESC);
    wire tick2 = pre_tick && (cks_reg[5:3] == CKS_PRESC);

    // Pin edge detection after the two-flop synchroniser.
    wire pin_rise = pin_s2_reg && !pin_prev_reg;
    wire pin_fall = !pin_s2_reg && pin_prev_reg;
    wire pin_edge = module_enable_bit && (edge_rise ? pin_rise : pin_fall);
    wire cap_edge = is_capture && pin_edge;
    wire preset1 = cap_edge && pin_en;

    // PWM drive: active in the non-capture modes with the pin enabled.
    wire pwm_on = module_enable_bit && pin_en && !is_capture;
    wire toggle = pwm_on && c1.underflow;
    wire toggle_rise = toggle && !mode_reg[BIT_LVL];

    // Counter one control.
    assign c1.tick = tick1;
    assign c1.load = wr_cnt1;
    assign c1.load_val = (c1.count & ~lane_mask) | (wdata_reg[15:0] & lane_mask);
    assign c1.preset = preset1;
    assign c1.reload_en = !is_capture;
    assign c1.reload_val = rc1_reg;

    // Counter two control.
    assign c2.tick = tick2;
    assign c2.load = wr_cnt2;
    assign c2.load_val = (c2.count & ~lane_mask) | (wdata_reg[15:0] & lane_mask);
    assign c2.preset = 1'b0;
    assign c2.reload_en = 1'b1;
    assign c2.reload_val = rl2_reg;

    mft_counter u_cnt1 (
        .aclk(aclk),
        .cif(c1.cnt)
    );

    mft_counter u_cnt2 (
        .aclk(aclk),
        .cif(c2.cnt)
    );

    // Hardware events per source, bit 0 is source A.
    wire [3:0] hw_ev;
    assign hw_ev[0] = ((is_pwm || is_dual) && c1.underflow) || cap_edge;
    assign hw_ev[1] = 1'b0;
    assign hw_ev[2] = (is_capture && c1.underflow) || (is_dual && toggle_rise);
    assign hw_ev[3] = c2.underflow;

    // Software set and clear strobes for pending bits.
    wire [3:0] sw_set = wr_int ? wdata_reg[3:0] : 4'h0;
    wire [3:0] sw_clr = wr_clr ? wdata_reg[3:0] : 4'h0;

    // One pending flag per source; a set beats a clear in the same cycle.
    genvar gi;
    generate
        for (gi = 0; gi < 4; gi++) begin : g_pend
            always_comb begin
                if (!mode_next[BIT_TEN]) begin
                    pend_next[gi] = 1'b0;
                end else begin
                    pend_next[gi] = (pend_reg[gi] && !sw_clr[gi])
                        || hw_ev[gi] || (sw_set[gi] && module_enable_bit);
                end
            end
        end
    endgenerate

    // Mode register: software write wins over the hardware toggle.
    always_comb begin
        mode_next = mode_reg;
        if (wr_mode) begin
            mode_next = wdata_reg[7:0] & MODE_WMASK;
        end else if (toggle) begin
            mode_next[BIT_LVL] = !mode_reg[BIT_LVL];
        end
    end

    // Read data selection.
    wire [ADDR_W-1:0] ra = s_axi_araddr;
    wire ra_hit = (ra == OFS_CNT1) || (ra == OFS_CNT2) || (ra == OFS_RC1)
        || (ra == OFS_RL2) || (ra == OFS_MODE) || (ra == OFS_INT)
        || (ra == OFS_CLR) || (ra == OFS_PRE) || (ra == OFS_CKS);
    logic [31:0] rd_mux;
    always_comb begin
        rd_mux = 32'h0000_0000;
        case (ra)
            OFS_CNT1: rd_mux = {16'h0000, c1.count};
            OFS_CNT2: rd_mux = {16'h0000, c2.count};
            OFS_RC1: rd_mux = {16'h0000, rc1_reg};
            OFS_RL2: rd_mux = {16'h0000, rl2_reg};
            OFS_MODE: rd_mux = {24'h000000, mode_reg};
            OFS_INT: rd_mux = {24'h000000, ien_reg[7:4], pend_reg};
            OFS_CLR: rd_mux = {24'h000000, CLR_READ};
            OFS_PRE: rd_mux = {27'h0, presc_reg};
            OFS_CKS: rd_mux = {26'h0, cks_reg};
            default: rd_mux = 32'h0000_0000;
        endcase
    end

    // Write address and data channels, each held until the commit.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            awready_reg <= 1'b1;
            wready_reg <= 1'b1;
            waddr_reg <= '0;
            wdata_reg <= 32'h0000_0000;
            wstrb_reg <= 4'h0;
        end else begin
            if (s_axi_awvalid && awready_reg) begin
                awready_reg <= 1'b0;
                waddr_reg <= s_axi_awaddr;
            end else if (wr_fire) begin
                awready_reg <= 1'b1;
            end
            if (s_axi_wvalid && wready_reg) begin
                wready_reg <= 1'b0;
                wdata_reg <= s_axi_wdata;
                wstrb_reg <= s_axi_wstrb;
            end else if (wr_fire) begin
                wready_reg <= 1'b1;
            end
        end
    end

    // Write response; unmapped addresses answer with a slave error.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            bvalid_reg <= 1'b0;
            bresp_reg <= RESP_OKAY;
        end else if (wr_fire) begin
            bvalid_reg <= 1'b1;
            bresp_reg <= wa_hit ? RESP_OKAY : RESP_SLVERR;
        end else if (s_axi_bready) begin
            bvalid_reg <= 1'b0;
        end
    end

    // Read channel: data is ready one cycle after the address is taken.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            arready_reg <= 1'b1;
            rvalid_reg <= 1'b0;
            rdata_reg <= 32'h0000_0000;
            rresp_reg <= RESP_OKAY;
        end else if (ar_fire) begin
            arready_reg <= 1'b0;
            rvalid_reg <= 1'b1;
            rdata_reg <= rd_mux;
            rresp_reg <= ra_hit ? RESP_OKAY : RESP_SLVERR;
        end else if (rvalid_reg && s_axi_rready) begin
            rvalid_reg <= 1'b0;
            arready_reg <= 1'b1;
        end
    end

    // Control registers with reset.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            mode_reg <= MODE_RST;
            ien_reg <= INT_RST;
            pend_reg <= 4'h0;
            cks_reg <= CKS_RST;
        end else begin
            mode_reg <= mode_next;
            pend_reg <= pend_next;
            if (wr_int) begin
                ien_reg <= wdata_reg[7:0];
            end
            if (byte0 && wa_cks) begin
                cks_reg <= wdata_reg[5:0];
            end
        end
    end

    // Prescaler divisor and its running count, both zero while disabled.
    always_ff @(posedge aclk) begin
        if (!aresetn || !module_enable_bit) begin
            presc_reg <= PRE_RST;
            pcnt_reg <= PRE_RST;
        end else begin
            if (byte0 && wa_pre) begin
                presc_reg <= wdata_reg[4:0];
            end
            pcnt_reg <= pre_tick ? PRE_RST : pcnt_reg + 5'h01;
        end
    end

    // Reload registers keep their contents through reset.
    always_ff @(posedge aclk) begin
        if (wr_rc1) begin
            rc1_reg <= (rc1_reg & ~lane_mask) | (wdata_reg[15:0] & lane_mask);
        end else if (cap_edge) begin
            rc1_reg <= c1.count;
        end
        if (wr_rl2) begin
            rl2_reg <= (rl2_reg & ~lane_mask) | (wdata_reg[15:0] & lane_mask);
        end
    end

    // Pin synchroniser; only the second stage feeds the edge logic.
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pin_s1_reg <= 1'b0;
            pin_s2_reg <= 1'b0;
            pin_prev_reg <= 1'b0;
        end else begin
            pin_s1_reg <= timer_pin_one_in;
            pin_s2_reg <= pin_s1_reg;
            pin_prev_reg <= pin_s2_reg;
        end
    end

    // Pin drive and interrupts, registered from next-state values.
    wire pwm_next = mode_next[BIT_TEN] && mode_next[BIT_PEN]
        && (mft_mode_t'(mode_next[1:0]) != MODE_CAPTURE);
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pin_out_reg <= 1'b0;
            pin_oe_reg <= 1'b0;
            irq1_reg <= 1'b0;
            irq2_reg <= 1'b0;
        end else begin
            pin_out_reg <= mode_next[BIT_LVL] && pwm_next;
            pin_oe_reg <= pwm_next;
            irq1_reg <= |(pend_next[2:0] & ien_reg[6:4]);
            irq2_reg <= pend_next[3] && ien_reg[7];
        end
    end

    // Outputs.
    assign s_axi_awready = awready_reg;
    assign s_axi_wready = wready_reg;
    assign s_axi_bvalid = bvalid_reg;
    assign s_axi_bresp = bresp_reg;
    assign s_axi_arready = arready_reg;
    assign s_axi_rvalid = rvalid_reg;
    assign s_axi_rdata = rdata_reg;
    assign s_axi_rresp = rresp_reg;
    assign timer_pin_one_out = pin_out_reg;
    assign timer_pin_one_oe = pin_oe_reg;
    assign timer_irq_one = irq1_reg;
    assign timer_irq_two = irq2_reg;
endmodule

/* common/mft_pkg.sv */
// Constants and types shared by the timer register block.
// What this block does
// - Counter one count is a 16-bit read/write register, untouched by reset.
// - Counter two count is a 16-bit read/write register, untouched by reset.
// - Reload/capture one is 16-bit read/write, reload or capture by mode.
// - Reload two is 16-bit read/write, counter two reload value.
// - Mode control resets to zero; enable 7, level 6, pin 4, edge 2, mode 1:0.
// - Mode 00 PWM, 01 capture, 10 dual counters, 11 reserved.
// - Edge bit 0 selects falling pin edges, 1 selects rising edges.
// - Capture mode with pin enabled: each active edge presets counter one to ffff.
// - Other modes: pin enable makes the pin a PWM output; clear leaves it idle.
// - Output level bit tracks the PWM pin; hardware and software may change it.
// - Software write beats a same-cycle hardware toggle of the level bit.
// - Output level bit has no effect while the pin is an input.
// - Module enable clear stops counter clocks; set enables the timer.
// - While disabled, writes to counts, reloads and pending bits are ignored.
// - While disabled, prescaler and pending bits are zero and pin is input.
// - Interrupt control resets to zero; enables D..A in 7:4, pending D..A in 3:0.
// - Pending flags set by hardware or by writing 1; writing 0 is ignored.
// - Each source signals an interrupt only while its enable is set.
// - Writing 1 to clear bits 0..3 clears pending A..D; 0 does nothing.
// - Reading the interrupt clear register returns all ones.
// - Sources A, B, C drive timer interrupt one; D drives interrupt two.
// - Counter one reloads on underflow outside capture mode (ffff in capture); counter two reloads from its own register.
// - A counter stops with clock select 000 and counts with code 001.
package mft_pkg;
    localparam int ADDR_W = 6;
    localparam logic [ADDR_W-1:0] OFS_CNT1 = 6'h00;
    localparam logic [ADDR_W-1:0] OFS_CNT2 = 6'h04;
    localparam logic [ADDR_W-1:0] OFS_RC1 = 6'h08;
    localparam logic [ADDR_W-1:0] OFS_RL2 = 6'h0c;
    localparam logic [ADDR_W-1:0] OFS_MODE = 6'h10;
    localparam logic [ADDR_W-1:0] OFS_INT = 6'h14;
    localparam logic [ADDR_W-1:0] OFS_CLR = 6'h18;
    localparam logic [ADDR_W-1:0] OFS_PRE = 6'h1c;
    localparam logic [ADDR_W-1:0] OFS_CKS = 6'h20;
    // Mode control field positions.
    localparam int BIT_TEN = 7;
    localparam int BIT_LVL = 6;
    localparam int BIT_PEN = 4;
    localparam int BIT_EDG = 2;
    localparam logic [7:0] MODE_WMASK = 8'hd7;
    localparam logic [7:0] MODE_RST = 8'h00;
    localparam logic [7:0] INT_RST = 8'h00;
    localparam logic [7:0] CLR_READ = 8'hff;
    localparam logic [4:0] PRE_RST = 5'h00;
    localparam logic [5:0] CKS_RST = 6'h00;
    localparam logic [2:0] CKS_STOP = 3'h0;
    localparam logic [2:0] CKS_PRESC = 3'h1;
    localparam logic [15:0] CNT_PRESET = 16'hffff;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    typedef enum logic [1:0] {MODE_PWM, MODE_CAPTURE, MODE_DUAL, MODE_RSVD} mft_mode_t;
endpackage

/* common/mft_cnt_if.sv */
// Interface between the register block and one down counter.
`timescale 1ns/100ps
interface mft_cnt_if;
    logic tick;
    logic load;
    logic [15:0] load_val;
    logic preset;
    logic reload_en;
    logic [15:0] reload_val;
    logic [15:0] count;
    logic underflow;
    modport ctl (output tick, load, load_val, preset, reload_en, reload_val,
        input count, underflow);
    modport cnt (input tick, load, load_val, preset, reload_en, reload_val,
        output count, underflow);
endinterface

/* logic/mft_counter.sv */
// Sixteen-bit down counter with reload, preset and software load.
`timescale 1ns/100ps
module mft_counter (
    // Clock.
    input wire logic aclk,
    // Control and count.
    mft_cnt_if.cnt cif
);
    import mft_pkg::*;

    logic [15:0] count_reg;
    logic [15:0] count_next;
    wire at_zero = (count_reg == 16'h0000);

    // Underflow is the tick that finds the counter at zero.
    assign cif.underflow = cif.tick && at_zero;
    assign cif.count = count_reg;

    // Software load first, then preset, then counting.
    always_comb begin
        count_next = count_reg;
        if (cif.load) begin
            count_next = cif.load_val;
        end else if (cif.preset) begin
            count_next = CNT_PRESET;
        end else if (cif.tick) begin
            if (at_zero) begin
                count_next = cif.reload_en ? cif.reload_val : CNT_PRESET;
            end else begin
                count_next = count_reg - 16'h0001;
            end
        end
    end

    // The count has no reset, so it powers up unknown.
    always_ff @(posedge aclk) begin
        count_reg <= count_next;
    end
endmodule

/* tb/mft_timer_regs_chk.sv */
// Concurrent checks on the bus and pin ports of the timer register block.
`timescale 1ns/100ps
module mft_timer_regs_chk (
    // Clock and reset.
    input wire logic aclk,
    input wire logic aresetn,
    // Write channels.
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // Read channels.
    input wire logic [mft_pkg::ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0] s_axi_rresp,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // Pin.
    input wire logic timer_pin_one_out,
    input wire logic timer_pin_one_oe
);
    import mft_pkg::*;
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);
    // Handshake steps of a write and a read.
    sequence s_wr_taken;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    endsequence
    sequence s_rd_taken;
        s_axi_arvalid && s_axi_arready;
    endsequence
    a_write_answer: assert property (s_wr_taken |-> ##[1:3] s_axi_bvalid)
        else $error("write response missing");
    a_wready_busy: assert property (s_axi_wvalid && s_axi_wready |=> !s_axi_wready)
        else $error("write data ready not lowered");
    a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped");
    a_read_answer: assert property (s_rd_taken |=> s_axi_rvalid)
        else $error("read data late");
    a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data dropped");
    a_unmapped_read: assert property (s_rd_taken ##0 s_axi_araddr > 6'h20 |=>
        s_axi_rresp == RESP_SLVERR && s_axi_rdata == 32'h0)
        else $error("unmapped read not refused");
    a_clr_reads_ones: assert property (s_rd_taken ##0 s_axi_araddr == OFS_CLR |=>
        s_axi_rdata == 32'h000000ff)
        else $error("clear register read wrong");
    a_pin_quiet: assert property (!timer_pin_one_oe |-> !timer_pin_one_out)
        else $error("pin level while input");
endmodule

/* tb/mft_pin_model.sv */
// Wire of the timer pin with the outside driver that stands on it.
`timescale 1ns/100ps
module mft_pin_model (
    // Levels from the block.
    input wire logic pin_out,
    input wire logic pin_oe,
    // Level of the outside driver.
    input wire logic ext_level,
    // Level fed back to the block.
    output logic pin_level
);
    // The outside driver backs off while the block drives the wire.
    assign pin_level = pin_oe ? pin_out : ext_level;
endmodule

/* tb/tb_top.sv */
// Self-checking bench of the timer register block.
`timescale 1ns/100ps
module tb_top;
    import mft_pkg::*;
    logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, bvalid, rvalid;
    logic awready, wready, arready, pin_in, pin_out, pin_oe, irq1, irq2, ext_level;
    logic [5:0] awaddr, araddr;
    logic [31:0] wdata, rdata;
    logic [1:0] bresp, rresp;
    logic [31:0] mreg [0:8];
    int failures, total_checks, cycles, i, a, n;
    // Device and pin.
    mft_timer_regs DUT (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
        .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready), .timer_pin_one_in(pin_in), .timer_pin_one_out(pin_out),
        .timer_pin_one_oe(pin_oe), .timer_irq_one(irq1), .timer_irq_two(irq2));
    mft_pin_model u_pin (.pin_out(pin_out), .pin_oe(pin_oe), .ext_level(ext_level),
        .pin_level(pin_in));
    // Clock and hang limit.
    initial begin
        aclk = 1'b0;
        forever #12.5 aclk = ~aclk;
    end
    always @(posedge aclk) begin
        cycles <= cycles + 1;
        if (cycles == 30000) begin
            failures++;
            report_and_stop();
        end
    end
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", total_checks, failures);
        if (failures == 0 && total_checks > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        total_checks++;
        if (g !== e) begin
            $display("unexpected %s expected %h seen %h", nm, e, g);
            failures++;
        end
    endtask
    // Model of the register file after one write.
    function automatic void mwr(input logic [5:0] ad, input logic [31:0] d);
        logic en;
        en = mreg[4][7];
        if (ad == OFS_MODE) begin
            mreg[4] = d & 32'hd7;
            if (!d[7]) mreg[5] = mreg[5] & 32'hf0;
        end
        else if (ad == OFS_INT) mreg[5] = {24'h0, d[7:4], en ? (mreg[5][3:0] | d[3:0]) : 4'h0};
        else if (ad == OFS_CLR) mreg[5] = mreg[5] & ~{28'h0, d[3:0]};
        else if (en && ad < 6'h10) mreg[ad[5:2]] = {16'h0, d[15:0]};
    endfunction
    // One bus write, address and data offered together.
    task automatic wr(input logic [5:0] ad, input logic [31:0] d);
        bit ga, gw;
        @(posedge aclk);
        awaddr <= ad;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'($urandom);
        ga = 0;
        gw = 0;
        while (!(ga && gw)) begin
            @(posedge aclk);
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
            ga |= awvalid && awready;
            gw |= wvalid && wready;
        end
        do @(posedge aclk); while (bvalid !== 1'b1);
        // A response seen while bready was low is taken at the next edge.
        if (!bready) begin
            bready <= 1'b1;
            @(posedge aclk);
        end
        bready <= 1'b0;
        chk("bresp", ad > 6'h20 ? RESP_SLVERR : RESP_OKAY, bresp);
        mwr(ad, d);
    endtask
    // One bus read compared with the model.
    task automatic rd_chk(input logic [5:0] ad);
        @(posedge aclk);
        araddr <= ad;
        arvalid <= 1'b1;
        rready <= 1'($urandom);
        do @(posedge aclk); while (arready !== 1'b1);
        arvalid <= 1'b0;
        do @(posedge aclk); while (rvalid !== 1'b1);
        if (!rready) begin
            rready <= 1'b1;
            @(posedge aclk);
        end
        rready <= 1'b0;
        chk("rresp", ad > 6'h20 ? RESP_SLVERR : RESP_OKAY, rresp);
        chk("rdata", ad == OFS_CLR ? 32'hff : (ad > 6'h20 ? 32'h0 : mreg[ad[5:2]]), rdata);
    endtask
    // Main sequence.
    initial begin
        {awvalid, wvalid, bready, arvalid, rready, ext_level} = 6'h00;
        awaddr = 6'h00;
        araddr = 6'h00;
        wdata = 32'h0;
        aresetn = 1'b0;
        cycles = 0;
        for (i = 0; i < 9; i++) mreg[i] = 32'h0;
        n = $urandom(32'h70c3d274);
        repeat (16) @(posedge aclk);
        aresetn <= 1'b1;
        rd_chk(OFS_MODE);
        rd_chk(OFS_INT);
        rd_chk(OFS_CLR);
        rd_chk(6'h24);
        wr(6'h24, 32'hffffffff);
        $display("test reset values done");
        wr(OFS_MODE, 32'hff);
        rd_chk(OFS_MODE);
        wr(OFS_MODE, 32'h80);
        for (i = 0; i < 2; i++) begin
            for (a = 0; a < 4; a++) wr(6'(a * 4), $urandom);
            for (a = 0; a < 4; a++) rd_chk(6'(a * 4));
            wr(OFS_MODE, 32'h00);
        end
        // A reset in mid-run clears the control state and keeps counts and reloads.
        wr(OFS_MODE, 32'h80);
        wr(OFS_INT, 32'hf5);
        @(posedge aclk);
        aresetn <= 1'b0;
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        mreg[4] = 32'h0;
        mreg[5] = 32'h0;
        for (a = 0; a < 6; a++) rd_chk(6'(a * 4));
        $display("test word registers done");
        wr(OFS_MODE, 32'h80);
        for (i = 0; i < 4; i++) begin
            wr(OFS_INT, 32'hf0 | (1 << i));
            wr(OFS_INT, 32'hf0);
            rd_chk(OFS_INT);
            repeat (2) @(posedge aclk);
            chk("irq_one", i < 3, irq1);
            chk("irq_two", i == 3, irq2);
            wr(OFS_INT, 32'h00);
            repeat (2) @(posedge aclk);
            chk("irq_off", 0, irq1 | irq2);
            wr(OFS_CLR, 32'h0);
            rd_chk(OFS_INT);
            wr(OFS_CLR, 1 << i);
            rd_chk(OFS_INT);
        end
        wr(OFS_INT, 32'h0f);
        wr(OFS_MODE, 32'h00);
        rd_chk(OFS_INT);
        wr(OFS_INT, 32'h0f);
        rd_chk(OFS_INT);
        $display("test pending flags done");
        wr(OFS_MODE, 32'h90);
        repeat (2) @(posedge aclk);
        chk("pin_oe", 1, pin_oe);
        chk("pin_out", 0, pin_out);
        wr(OFS_RC1, 32'h40);
        wr(OFS_CNT1, 32'h40);
        wr(OFS_CKS, 32'h01);
        n = 0;
        while (pin_out !== 1'b1 && n < 400) begin
            @(posedge aclk);
            n++;
        end
        wr(OFS_CKS, 32'h00);
        chk("pin_toggle", 1, pin_out);
        mreg[4] = 32'hd0;
        mreg[5] = mreg[5] | 32'h1;
        rd_chk(OFS_MODE);
        rd_chk(OFS_INT);
        wr(OFS_MODE, 32'h90);
        repeat (2) @(posedge aclk);
        chk("pin_sw", 0, pin_out);
        wr(OFS_CNT1, 32'h1234);
        wr(OFS_CLR, 32'h1);
        wr(OFS_MODE, 32'hd5);
        repeat (2) @(posedge aclk);
        chk("pin_in_oe", 0, pin_oe);
        ext_level <= 1'b1;
        repeat (6) @(posedge aclk);
        mreg[0] = 32'hffff;
        mreg[2] = 32'h1234;
        mreg[5] = 32'h1;
        rd_chk(OFS_CNT1);
        rd_chk(OFS_RC1);
        rd_chk(OFS_INT);
        wr(OFS_CNT1, 32'h1234);
        ext_level <= 1'b0;
        repeat (6) @(posedge aclk);
        rd_chk(OFS_CNT1);
        wr(OFS_MODE, 32'h90);
        wr(OFS_MODE, 32'h50);
        repeat (2) @(posedge aclk);
        chk("pin_off", 0, pin_oe);
        wr(OFS_CKS, 32'h01);
        repeat (4) @(posedge aclk);
        rd_chk(OFS_CNT1);
        $display("test pin functions done");
        report_and_stop();
    end
endmodule
bind mft_timer_regs mft_timer_regs_chk u_chk (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
    .timer_pin_one_out(timer_pin_one_out), .timer_pin_one_oe(timer_pin_one_oe));
